//--- logic/sptmr_pkg.sv
// Constants and types shared by the split-mode timer and timer control/status logic.
package sptmr_pkg;

	// ----------------------------------------
	// Control/status register layout
	// ----------------------------------------
	localparam int          TCS_T1_FLAG = 7;
	localparam int          TCS_T1_RUN  = 6;
	localparam int          TCS_T0_FLAG = 5;
	localparam int          TCS_T0_RUN  = 4;
	localparam int          TCS_XB_FLAG = 3;
	localparam int          TCS_XB_TYPE = 2;
	localparam int          TCS_XA_FLAG = 1;
	localparam int          TCS_XA_TYPE = 0;
	localparam logic [7:0]  TCS_RESET   = 8'h00;

	// ----------------------------------------
	// Mode register layout and mode codes
	// ----------------------------------------
	localparam int          TMR_SECOND_GATE_ENABLE   = 7;
	localparam int          TMR_SRC1    = 6;
	localparam int          TMR_M1_HI   = 5;
	localparam int          TMR_M1_LO   = 4;
	localparam int          TMR_FIRST_GATE_ENABLE   = 3;
	localparam int          TMR_SRC0    = 2;
	localparam int          TMR_M0_HI   = 1;
	localparam int          TMR_M0_LO   = 0;
	localparam logic [1:0]  MODE_13BIT  = 2'h0;
	localparam logic [1:0]  MODE_16BIT  = 2'h1;
	localparam logic [1:0]  MODE_RELOAD = 2'h2;
	localparam logic [1:0]  MODE_SPLIT  = 2'h3;

	// ----------------------------------------
	// Counter byte select codes and byte values
	// ----------------------------------------
	localparam logic [1:0]  SEL_T0_LOW  = 2'h0;
	localparam logic [1:0]  SEL_T0_HIGH = 2'h1;
	localparam logic [1:0]  SEL_T1_LOW  = 2'h2;
	localparam logic [1:0]  SEL_T1_HIGH = 2'h3;
	localparam logic [7:0]  BYTE_RESET  = 8'h00;
	localparam logic [7:0]  BYTE_FULL   = 8'hFF;

	typedef struct packed {
		logic [7:0] tcs;
		logic [7:0] t0_lo;
		logic [7:0] t0_hi;
		logic [7:0] t1_lo;
		logic [7:0] t1_hi;
		logic [2:0] ev_a_sync;
		logic [2:0] ev_b_sync;
		logic [2:0] gt_a_sync;
		logic [2:0] gt_b_sync;
		logic       ev_a_st;
		logic       ev_b_st;
		logic       gt_a_st;
		logic       gt_b_st;
		logic       baud;
	} sptmr_state_type;

endpackage : sptmr_pkg

//--- logic/sptmr_core.sv
// Split-mode timer pair with the timer control/status register.
`timescale 1ns/1ps
module sptmr_core
	import sptmr_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	output logic      [7:0] timer_control_status_o,
	input  wire logic [7:0] timer_mode_register_i,
	input  wire logic       first_clock_select_i,
	input  wire logic       second_clock_select_i,
	input  wire logic       prescale_tick_i,
	input  wire logic       cnt_wr_i,
	input  wire logic [1:0] cnt_sel_i,
	input  wire logic [7:0] cnt_wdata_i,
	output logic      [7:0] first_timer_low_byte_o,
	output logic      [7:0] first_timer_high_byte_o,
	output logic      [7:0] second_timer_low_byte_o,
	output logic      [7:0] second_timer_high_byte_o,
	input  wire logic       event_input_a_i,
	input  wire logic       event_input_b_i,
	input  wire logic       ext_gate_input_a_i,
	input  wire logic       ext_gate_input_b_i,
	input  wire logic       gate_a_polarity_i,
	input  wire logic       gate_b_polarity_i,
	input  wire logic       ack_first_timer_i,
	input  wire logic       ack_second_timer_i,
	input  wire logic       ack_ext_irq_a_i,
	input  wire logic       ack_ext_irq_b_i,
	output logic            first_timer_overflow_flag_o,
	output logic            second_timer_overflow_flag_o,
	output logic            ext_irq_a_flag_o,
	output logic            ext_irq_b_flag_o,
	output logic            baud_tick_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Returns {overflow, high, low} after one count in the given mode.
	function automatic logic [16:0] sptmr_step(input logic [1:0] mode,
	                                           input logic [7:0] lo,
	                                           input logic [7:0] hi);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [16:0] r;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h0_0001;
		case (mode)
			MODE_13BIT:  r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			MODE_16BIT:  r = s16;
			MODE_RELOAD: r = (lo == BYTE_FULL) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
			default:     r = {1'b0, hi, lo};
		endcase
		return r;
	endfunction : sptmr_step

	// A change is taken once the second and third stages agree.
	function automatic logic sptmr_filt(input logic [2:0] sync, input logic st);
		return (sync[1] == sync[2]) ? sync[2] : st;
	endfunction : sptmr_filt

	// ----------------------------------------
	// State
	// ----------------------------------------
	sptmr_state_type st_q;
	sptmr_state_type st_d;

	logic [1:0]  mode0;
	logic [1:0]  mode1;
	logic        split;
	logic        tick0;
	logic        tick1;
	logic        fall_a;
	logic        fall_b;
	logic        act_a_old;
	logic        act_a_new;
	logic        act_b_old;
	logic        act_b_new;
	logic        run0;
	logic        run1;
	logic        src0;
	logic        src1;
	logic        ovf0;
	logic        ovf0_hi;
	logic        ovf1;
	logic        set_tf0;
	logic        set_tf1;
	logic [8:0]  lo_sum;
	logic [8:0]  hi_sum;
	logic [16:0] step0;
	logic [16:0] step1;

	assign mode0 = timer_mode_register_i[TMR_M0_HI:TMR_M0_LO];
	assign mode1 = timer_mode_register_i[TMR_M1_HI:TMR_M1_LO];
	assign split = (mode0 == MODE_SPLIT);
	assign tick0 = first_clock_select_i | prescale_tick_i;
	assign tick1 = second_clock_select_i | prescale_tick_i;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		ovf0 = 1'b0;
		ovf0_hi = 1'b0;
		ovf1 = 1'b0;
		lo_sum = 9'h000;
		hi_sum = 9'h000;
		step0 = 17'h0_0000;
		step1 = 17'h0_0000;

		st_d.ev_a_sync = {st_q.ev_a_sync[1:0], event_input_a_i};
		st_d.ev_b_sync = {st_q.ev_b_sync[1:0], event_input_b_i};
		st_d.gt_a_sync = {st_q.gt_a_sync[1:0], ext_gate_input_a_i};
		st_d.gt_b_sync = {st_q.gt_b_sync[1:0], ext_gate_input_b_i};
		st_d.ev_a_st = sptmr_filt(st_q.ev_a_sync, st_q.ev_a_st);
		st_d.ev_b_st = sptmr_filt(st_q.ev_b_sync, st_q.ev_b_st);
		st_d.gt_a_st = sptmr_filt(st_q.gt_a_sync, st_q.gt_a_st);
		st_d.gt_b_st = sptmr_filt(st_q.gt_b_sync, st_q.gt_b_st);

		fall_a = st_q.ev_a_st & ~st_d.ev_a_st;
		fall_b = st_q.ev_b_st & ~st_d.ev_b_st;
		act_a_old = (st_q.gt_a_st == gate_a_polarity_i);
		act_a_new = (st_d.gt_a_st == gate_a_polarity_i);
		act_b_old = (st_q.gt_b_st == gate_b_polarity_i);
		act_b_new = (st_d.gt_b_st == gate_b_polarity_i);

		// First timer: whole counter, or the low byte in split mode.
		run0 = st_q.tcs[TCS_T0_RUN] & (~timer_mode_register_i[TMR_FIRST_GATE_ENABLE] | act_a_old);
		src0 = timer_mode_register_i[TMR_SRC0] ? fall_a : tick0;
		if (split) begin
			if (run0 && src0) begin
				lo_sum = {1'b0, st_q.t0_lo} + 9'h001;
				st_d.t0_lo = lo_sum[7:0];
				ovf0 = lo_sum[8];
			end
			// The high byte borrows the second timer's run bit and is never event driven.
			if (st_q.tcs[TCS_T1_RUN] && tick0) begin
				hi_sum = {1'b0, st_q.t0_hi} + 9'h001;
				st_d.t0_hi = hi_sum[7:0];
				ovf0_hi = hi_sum[8];
			end
		end else if (run0 && src0) begin
			step0 = sptmr_step(mode0, st_q.t0_lo, st_q.t0_hi);
			{ovf0, st_d.t0_hi, st_d.t0_lo} = step0;
		end

		// Second timer: in split mode its run bit and gate are ignored.
		if (split) begin
			run1 = (mode1 != MODE_SPLIT);
		end else begin
			run1 = st_q.tcs[TCS_T1_RUN] & (~timer_mode_register_i[TMR_SECOND_GATE_ENABLE] | act_b_old)
				& (mode1 != MODE_SPLIT);
		end
		src1 = (timer_mode_register_i[TMR_SRC1] && !split) ? fall_b : tick1;
		if (run1 && src1) begin
			step1 = sptmr_step(mode1, st_q.t1_lo, st_q.t1_hi);
			{ovf1, st_d.t1_hi, st_d.t1_lo} = step1;
		end
		st_d.baud = ovf1;

		// Software byte loads override a count in the same cycle.
		if (cnt_wr_i) begin
			if (cnt_sel_i == SEL_T0_LOW) begin
				st_d.t0_lo = cnt_wdata_i;
			end else if (cnt_sel_i == SEL_T0_HIGH) begin
				st_d.t0_hi = cnt_wdata_i;
			end else if (cnt_sel_i == SEL_T1_LOW) begin
				st_d.t1_lo = cnt_wdata_i;
			end else begin
				st_d.t1_hi = cnt_wdata_i;
			end
		end

		// Control/status: software write and vector clears first, hardware sets last.
		if (sfr_wr_i) begin
			st_d.tcs = sfr_wdata_i;
		end
		if (ack_first_timer_i) begin
			st_d.tcs[TCS_T0_FLAG] = 1'b0;
		end
		if (ack_second_timer_i) begin
			st_d.tcs[TCS_T1_FLAG] = 1'b0;
		end
		if (ack_ext_irq_a_i && st_q.tcs[TCS_XA_TYPE]) begin
			st_d.tcs[TCS_XA_FLAG] = 1'b0;
		end
		if (ack_ext_irq_b_i && st_q.tcs[TCS_XB_TYPE]) begin
			st_d.tcs[TCS_XB_FLAG] = 1'b0;
		end
		set_tf0 = ovf0;
		set_tf1 = split ? ovf0_hi : ovf1;
		if (set_tf0) begin
			st_d.tcs[TCS_T0_FLAG] = 1'b1;
		end
		if (set_tf1) begin
			st_d.tcs[TCS_T1_FLAG] = 1'b1;
		end
		// Level type follows the pin, so a software clear only sticks once it is inactive.
		if (st_q.tcs[TCS_XA_TYPE]) begin
			if (act_a_new && !act_a_old) begin
				st_d.tcs[TCS_XA_FLAG] = 1'b1;
			end
		end else begin
			st_d.tcs[TCS_XA_FLAG] = act_a_new;
		end
		if (st_q.tcs[TCS_XB_TYPE]) begin
			if (act_b_new && !act_b_old) begin
				st_d.tcs[TCS_XB_FLAG] = 1'b1;
			end
		end else begin
			st_d.tcs[TCS_XB_FLAG] = act_b_new;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign timer_control_status_o       = st_q.tcs;
	assign first_timer_low_byte_o       = st_q.t0_lo;
	assign first_timer_high_byte_o      = st_q.t0_hi;
	assign second_timer_low_byte_o      = st_q.t1_lo;
	assign second_timer_high_byte_o     = st_q.t1_hi;
	assign first_timer_overflow_flag_o  = st_q.tcs[TCS_T0_FLAG];
	assign second_timer_overflow_flag_o = st_q.tcs[TCS_T1_FLAG];
	assign ext_irq_a_flag_o             = st_q.tcs[TCS_XA_FLAG];
	assign ext_irq_b_flag_o             = st_q.tcs[TCS_XB_FLAG];
	assign baud_tick_o                  = st_q.baud;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_t1_wrap;
		split && mode1 == MODE_16BIT && second_clock_select_i && !cnt_wr_i
			&& st_q.t1_lo == BYTE_FULL && st_q.t1_hi == BYTE_FULL;
	endsequence
	// The high byte must not be about to wrap, or its legal flag set would make the check fail.
	sequence s_t1_quiet;
		!st_q.tcs[TCS_T1_FLAG] && !sfr_wr_i
			&& !(st_q.tcs[TCS_T1_RUN] && st_q.t0_hi == BYTE_FULL);
	endsequence

	a_low_byte_count: assert property (
		split && st_q.tcs[TCS_T0_RUN] && !timer_mode_register_i[TMR_FIRST_GATE_ENABLE]
		&& !timer_mode_register_i[TMR_SRC0] && first_clock_select_i && !cnt_wr_i
		|=> st_q.t0_lo == $past(st_q.t0_lo) + 8'h01)
		else $error("low byte did not count in split mode");
	a_high_byte_hold: assert property (
		split && !st_q.tcs[TCS_T1_RUN] && !cnt_wr_i |=> $stable(st_q.t0_hi))
		else $error("high byte counted without second run bit");
	a_high_byte_tick: assert property (
		split && !first_clock_select_i && !prescale_tick_i && !cnt_wr_i
		|=> $stable(st_q.t0_hi))
		else $error("high byte counted without a timer tick");
	a_high_ovf_flag: assert property (
		split && st_q.tcs[TCS_T1_RUN] && (first_clock_select_i || prescale_tick_i)
		&& !cnt_wr_i && st_q.t0_hi == BYTE_FULL
		|=> st_q.tcs[TCS_T1_FLAG] ##0 st_q.t0_hi == BYTE_RESET)
		else $error("high byte overflow did not set second flag");
	a_mode3_stop: assert property (
		mode1 == MODE_SPLIT && !cnt_wr_i |=> $stable({st_q.t1_hi, st_q.t1_lo}))
		else $error("second timer moved in mode 3");
	a_split_baud: assert property (
		s_t1_wrap |=> baud_tick_o ##1 !baud_tick_o)
		else $error("baud pulse missing in split mode");
	a_split_no_flag: assert property (
		s_t1_wrap ##0 s_t1_quiet |=> !st_q.tcs[TCS_T1_FLAG])
		else $error("second timer set its flag in split mode");
	a_split_ignore_run: assert property (
		split && mode1 == MODE_16BIT && !st_q.tcs[TCS_T1_RUN] && second_clock_select_i
		&& !cnt_wr_i |=> {st_q.t1_hi, st_q.t1_lo} == $past({st_q.t1_hi, st_q.t1_lo}) + 16'h0001)
		else $error("second timer not running in split mode");
	a_flag_set_wins: assert property (
		set_tf0 |=> st_q.tcs[TCS_T0_FLAG])
		else $error("first overflow flag lost");
	a_gate_bypass: assert property (
		mode0 == MODE_16BIT && st_q.tcs[TCS_T0_RUN] && !timer_mode_register_i[TMR_FIRST_GATE_ENABLE]
		&& !timer_mode_register_i[TMR_SRC0] && (first_clock_select_i || prescale_tick_i)
		&& !cnt_wr_i
		|=> {st_q.t0_hi, st_q.t0_lo} == $past({st_q.t0_hi, st_q.t0_lo}) + 16'h0001)
		else $error("gate blocked an ungated timer");
	a_prescale_hold: assert property (
		!split && !timer_mode_register_i[TMR_SRC0] && !first_clock_select_i
		&& !prescale_tick_i && !cnt_wr_i |=> $stable({st_q.t0_hi, st_q.t0_lo}))
		else $error("timer counted without prescaled tick");
	a_vector_clear: assert property (
		ack_first_timer_i && !set_tf0 && !sfr_wr_i |=> !st_q.tcs[TCS_T0_FLAG])
		else $error("vectoring did not clear first flag");

endmodule : sptmr_core

//--- test/sptmr_pins.sv
// Behavioural model of the external event and gate pins.
`timescale 1ns/1ps
module sptmr_pins (
	input  wire logic clk_i,
	output logic      event_a_o,
	output logic      event_b_o,
	output logic      gate_a_o,
	output logic      gate_b_o
);
	// Events idle high so that only a deliberate fall is counted.
	initial begin
		event_a_o = 1'b1;
		event_b_o = 1'b1;
		gate_a_o  = 1'b0;
		gate_b_o  = 1'b0;
	end

	// Each level is held at least three cycles, so the pin sampler cannot miss it.
	task automatic events(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			event_a_o <= 1'b0;
			event_b_o <= 1'b0;
			repeat (3) @(posedge clk_i);
			event_a_o <= 1'b1;
			event_b_o <= 1'b1;
			repeat (3) @(posedge clk_i);
		end
	endtask : events

	task automatic set_gate(input logic a, input logic b);
		@(posedge clk_i);
		gate_a_o <= a;
		gate_b_o <= b;
	endtask : set_gate
endmodule : sptmr_pins

//--- test/tb_top.sv
// Self-checking bench for the split-mode timer and its control/status register.
`timescale 1ns/1ps
module tb_top;
	import sptmr_pkg::*;
	typedef struct {
		logic [7:0]  mode;
		logic [7:0]  run;
		int          n;
		logic [31:0] pre;
		logic [31:0] res;
		logic [7:0]  tcs;
		int          baud;
	} sptmr_row_type;
	logic          clk_i;
	logic          sys_rst_i;
	logic          sfr_wr_i;
	logic [7:0]    sfr_wdata_i;
	logic [7:0]    mode_reg;
	logic          clk_sel;
	logic          clk_sel2;
	logic          tick;
	logic          cnt_wr;
	logic [1:0]    cnt_sel;
	logic [7:0]    cnt_wdata;
	logic [3:0]    ack;
	wire  [7:0]    tcs;
	wire  [3:0]    flags;
	wire  [31:0]   bytes_o;
	wire           baud;
	wire           ev_a, ev_b, gt_a, gt_b;
	int            n_mismatch = 0;
	int            checks_done = 0;
	int            n_baud = 0;
	sptmr_row_type rows [7];

	sptmr_core sptmr_core_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_wr_i(sfr_wr_i),
		.sfr_wdata_i(sfr_wdata_i), .timer_control_status_o(tcs),
		.timer_mode_register_i(mode_reg), .first_clock_select_i(clk_sel),
		.second_clock_select_i(clk_sel2), .prescale_tick_i(tick), .cnt_wr_i(cnt_wr),
		.cnt_sel_i(cnt_sel), .cnt_wdata_i(cnt_wdata),
		.first_timer_low_byte_o(bytes_o[31:24]), .first_timer_high_byte_o(bytes_o[23:16]),
		.second_timer_low_byte_o(bytes_o[15:8]), .second_timer_high_byte_o(bytes_o[7:0]),
		.event_input_a_i(ev_a), .event_input_b_i(ev_b), .ext_gate_input_a_i(gt_a),
		.ext_gate_input_b_i(gt_b), .gate_a_polarity_i(1'b1), .gate_b_polarity_i(1'b1),
		.ack_first_timer_i(ack[0]), .ack_second_timer_i(ack[1]), .ack_ext_irq_a_i(ack[2]),
		.ack_ext_irq_b_i(ack[3]), .first_timer_overflow_flag_o(flags[2]),
		.second_timer_overflow_flag_o(flags[3]), .ext_irq_a_flag_o(flags[0]),
		.ext_irq_b_flag_o(flags[1]),
		.baud_tick_o(baud));
	sptmr_pins sptmr_pins_i (.clk_i(clk_i), .event_a_o(ev_a), .event_b_o(ev_b),
		.gate_a_o(gt_a), .gate_b_o(gt_b));

	// ----------------------------------------
	// Clock, baud counter and helpers
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (baud === 1'b1) n_baud++;
	end

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_byte
	task automatic cmp_count(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			n_mismatch++;
			$display("mismatch at %0t: baud count %0d expected %0d", $time, got, exp);
		end
	endtask : cmp_count
	task automatic wr_tcs(input logic [7:0] v);
		@(posedge clk_i);
		sfr_wr_i <= 1'b1;
		sfr_wdata_i <= v;
		@(posedge clk_i);
		sfr_wr_i <= 1'b0;
	endtask : wr_tcs
	task automatic pulse_tick(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			tick <= 1'b1;
			@(posedge clk_i);
			tick <= 1'b0;
		end
	endtask : pulse_tick
	task automatic ack_pulse(input int b);
		@(posedge clk_i);
		ack[b] <= 1'b1;
		@(posedge clk_i);
		ack[b] <= 1'b0;
	endtask : ack_pulse
	// Run bits are cleared and no tick or event is driven while loading, so a load never races a count.
	task automatic setup(input logic [7:0] mode, input logic [31:0] pre, input logic [7:0] run);
		wr_tcs(8'h00);
		mode_reg <= mode;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			cnt_wr <= 1'b1;
			cnt_sel <= 2'(i);
			cnt_wdata <= pre[31 - 8 * i -: 8];
		end
		@(posedge clk_i);
		cnt_wr <= 1'b0;
		n_baud = 0;
		wr_tcs(run);
	endtask : setup
	task automatic cmp_all(input logic [31:0] res, input logic [7:0] exp_tcs);
		repeat (2) @(posedge clk_i);
		// Looked at mid-cycle, well clear of the edge that updates the outputs.
		@(negedge clk_i);
		for (int i = 0; i < 4; i++) cmp_byte(bytes_o[31 - 8 * i -: 8], res[31 - 8 * i -: 8]);
		cmp_byte(tcs, exp_tcs);
		cmp_byte({4'h0, flags}, {4'h0, exp_tcs[7], exp_tcs[5], exp_tcs[3], exp_tcs[1]});
	endtask : cmp_all
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		$display("mismatch at %0t: run did not finish", $time);
		end_sim();
	end
	initial begin
		{sys_rst_i, sfr_wr_i, sfr_wdata_i, mode_reg, clk_sel, tick} = {1'b1, 19'h0_0000};
		{cnt_wr, cnt_sel, cnt_wdata, ack} = 15'h0000;
		clk_sel2 = 1'b0;
		rows[0] = '{8'h33, 8'h10, 3, 32'hFE10_0506, 32'h0110_0506, 8'h30, 0};
		rows[1] = '{8'h33, 8'h40, 3, 32'h07FE_0506, 32'h0701_0506, 8'hC0, 0};
		rows[2] = '{8'h13, 8'h00, 3, 32'h0000_FEFF, 32'h0000_0100, 8'h00, 1};
		rows[3] = '{8'h23, 8'h40, 3, 32'h0000_FE80, 32'h0003_8180, 8'h40, 1};
		rows[4] = '{8'h03, 8'h00, 3, 32'h0000_FEFF, 32'h0000_E100, 8'h00, 1};
		rows[5] = '{8'h11, 8'h50, 2, 32'hFEFF_FFFF, 32'h0000_0100, 8'hF0, 1};
		rows[6] = '{8'h22, 8'h10, 1, 32'hFF40_0000, 32'h4040_0000, 8'h30, 0};
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		foreach (rows[r]) begin
			setup(rows[r].mode, rows[r].pre, rows[r].run);
			pulse_tick(rows[r].n);
			cmp_all(rows[r].res, rows[r].tcs);
			cmp_count(n_baud, rows[r].baud);
			$display("row %0d done", r);
		end
		setup(8'h57, 32'h0000_0000, 8'h50);
		sptmr_pins_i.events(3);
		cmp_all(32'h0300_0000, 8'h50);
		$display("event count test done");
		setup(8'h3B, 32'h0000_0000, 8'h10);
		pulse_tick(2);
		cmp_all(32'h0000_0000, 8'h10);
		sptmr_pins_i.set_gate(1'b1, 1'b0);
		repeat (5) @(posedge clk_i);
		pulse_tick(2);
		cmp_all(32'h0200_0000, 8'h12);
		sptmr_pins_i.set_gate(1'b0, 1'b0);
		repeat (5) @(posedge clk_i);
		$display("gate test done");
		setup(8'h33, 32'h0000_0000, 8'h10);
		@(posedge clk_i);
		clk_sel <= 1'b1;
		repeat (4) @(posedge clk_i);
		clk_sel <= 1'b0;
		cmp_all(32'h0400_0000, 8'h10);
		$display("clock select test done");
		setup(8'h13, 32'h0000_FFFF, 8'h00);
		@(posedge clk_i);
		clk_sel2 <= 1'b1;
		repeat (3) @(posedge clk_i);
		clk_sel2 <= 1'b0;
		cmp_all(32'h0000_0200, 8'h00);
		cmp_count(n_baud, 1);
		$display("second timer split test done");
		setup(8'h11, 32'hFFFF_FFFF, 8'h50);
		pulse_tick(1);
		cmp_all(32'h0000_0000, 8'hF0);
		ack_pulse(0);
		cmp_all(32'h0000_0000, 8'hD0);
		wr_tcs(8'h01);
		cmp_all(32'h0000_0000, 8'h01);
		$display("flag clear test done");
		sptmr_pins_i.set_gate(1'b1, 1'b0);
		repeat (5) @(posedge clk_i);
		cmp_all(32'h0000_0000, 8'h03);
		sptmr_pins_i.set_gate(1'b1, 1'b1);
		repeat (5) @(posedge clk_i);
		cmp_all(32'h0000_0000, 8'h0B);
		ack_pulse(2);
		cmp_all(32'h0000_0000, 8'h09);
		sptmr_pins_i.set_gate(1'b0, 1'b0);
		repeat (5) @(posedge clk_i);
		cmp_all(32'h0000_0000, 8'h01);
		wr_tcs(8'h05);
		sptmr_pins_i.set_gate(1'b0, 1'b1);
		repeat (5) @(posedge clk_i);
		cmp_all(32'h0000_0000, 8'h0D);
		ack_pulse(3);
		cmp_all(32'h0000_0000, 8'h05);
		sptmr_pins_i.set_gate(1'b0, 1'b0);
		repeat (5) @(posedge clk_i);
		$display("external flag test done");
		setup(8'h11, 32'h1234_5678, 8'h50);
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		cmp_all(32'h0000_0000, TCS_RESET);
		@(posedge clk_i);
		sys_rst_i <= 1'b0;
		cmp_all(32'h0000_0000, TCS_RESET);
		$display("reset test done");
		end_sim();
	end
endmodule : tb_top
